/* design/split_timer_params.svh */
// Register offsets, field positions and timing counts of the split auto-reload timer
`ifndef SPLIT_TIMER_PARAMS_SVH
`define SPLIT_TIMER_PARAMS_SVH
`define ADDR_CONTROL      8'h91
`define ADDR_RELOAD_LOW   8'h92
`define ADDR_RELOAD_HIGH  8'h93
`define ADDR_COUNT_LOW    8'h94
`define ADDR_COUNT_HIGH   8'h95
`define BIT_HIGH_OVF      7
`define BIT_LOW_OVF       6
`define BIT_LOW_IRQ_EN    5
`define BIT_SPLIT         3
`define BIT_RUN           2
`define BIT_EXT_SEL       0
`define CONTROL_WMASK     8'hed
`define RESET_BYTE        8'h00
`define SYS_DIV           4'hb
`define EXT_DIV           3'h7
`endif

/* design/split_timer_pkg.sv */
// Types shared by the split auto-reload timer
`default_nettype none
package split_timer_pkg;
   typedef logic [7:0] byte_t;
   typedef enum logic [1:0] {
      TICK_DIV12,
      TICK_EXT8,
      TICK_SYS
   } tick_src_t;
endpackage
`default_nettype wire

/* design/split_auto_reload_timer.sv */
// Split auto-reload timer: 16-bit or dual 8-bit counter with byte registers
// Overview of operation
// - Control bit 3 selects 16-bit or split.
// - 16-bit wrap reloads and sets high flag.
// - Interrupt on each 16-bit overflow when enabled.
// - Low-byte wrap interrupts when low enable set.
// - Split counters reload from their own bytes.
// - Split: run bit gates high counter only.
// - 16-bit: run bit starts and stops timer.
// - High clock: div12, ext div8, or system.
// - Low clock uses same encoding, shared ext.
// - Ext select picks div12 or ext div8.
// - External tick synchronised to system clock.
// - Split wraps set high and low flags.
// - Split interrupts: high, or either with enable.
// - Low flag sets on every low wrap.
// - Flags cleared only by software writes.
// - Bits 4 and 1 read zero.
// - Control field layout, reset all zero.
// - Low count register readable, writable, zero reset.
// - High count register readable, writable, zero reset.
// - Reload bytes hold value, untouched by counting.
`default_nettype none
`include "split_timer_params.svh"
module split_auto_reload_timer (
   // Clock and reset
   input  wire logic                  clk_sys_i,
   input  wire logic                  reset_i,
   // Byte register port
   input  wire logic [7:0]            reg_addr_i,
   input  wire split_timer_pkg::byte_t reg_wdata_i,
   input  wire logic                  reg_write_i,
   output var  split_timer_pkg::byte_t reg_rdata_o,
   // Clock selection, interrupt enable and external oscillator
   input  wire logic                  high_clock_select_i,
   input  wire logic                  low_clock_select_i,
   input  wire logic                  timer_irq_enable_i,
   input  wire logic                  ext_osc_i,
   // Interrupt request
   output logic                       irq_o
);
   import split_timer_pkg::*;

   byte_t     control_reg;
   byte_t     reload_low_reg;
   byte_t     reload_high_reg;
   byte_t     count_low_reg;
   byte_t     count_high_reg;
   logic      ext_meta_reg;
   logic      ext_sync_reg;
   logic      ext_prev_reg;
   logic [2:0] ext_div_reg;
   logic      ext_tick_reg;
   logic [3:0] sys_div_reg;
   logic      sys_tick;
   logic      ext_sel;
   logic      split;
   logic      run;
   logic      tick_low;
   logic      tick_high;
   logic      low_wrap;
   logic      high_wrap;
   logic      en_low;
   logic      en_high;
   logic      wr_ctrl;
   logic      wr_low;
   logic      wr_high;
   tick_src_t src_low;
   tick_src_t src_high;

   assign ext_sel = control_reg[`BIT_EXT_SEL];
   assign split   = control_reg[`BIT_SPLIT];
   assign run     = control_reg[`BIT_RUN];
   assign wr_ctrl = reg_write_i && (reg_addr_i == `ADDR_CONTROL);
   assign wr_low  = reg_write_i && (reg_addr_i == `ADDR_COUNT_LOW);
   assign wr_high = reg_write_i && (reg_addr_i == `ADDR_COUNT_HIGH);

   // System clock divide by twelve
   always_ff @(posedge clk_sys_i) begin
      if (reset_i || sys_div_reg == `SYS_DIV) begin
         sys_div_reg <= 4'h0;
      end else begin
         sys_div_reg <= sys_div_reg + 4'h1;
      end
   end
   assign sys_tick = (sys_div_reg == `SYS_DIV);

   // External oscillator synchroniser, edge count and divide by eight
   always_ff @(posedge clk_sys_i) begin
      if (reset_i) begin
         ext_meta_reg <= 1'b0;
         ext_sync_reg <= 1'b0;
         ext_prev_reg <= 1'b0;
         ext_div_reg  <= 3'h0;
         ext_tick_reg <= 1'b0;
      end else begin
         ext_meta_reg <= ext_osc_i;
         ext_sync_reg <= ext_meta_reg;
         ext_prev_reg <= ext_sync_reg;
         ext_tick_reg <= 1'b0;
         if (ext_sync_reg && !ext_prev_reg) begin
            ext_div_reg <= ext_div_reg + 3'h1;
            ext_tick_reg <= (ext_div_reg == `EXT_DIV);
         end
      end
   end

   // Tick source per byte; 16-bit mode uses the low select
   always_comb begin
      src_low  = low_clock_select_i ? TICK_SYS : (ext_sel ? TICK_EXT8 : TICK_DIV12);
      src_high = high_clock_select_i ? TICK_SYS : (ext_sel ? TICK_EXT8 : TICK_DIV12);
   end

   // Tick chosen by source code; the unused code gives no tick
   function automatic logic pick(input tick_src_t s, input logic st, input logic et);
      pick = 1'b0;
      unique case (s)
         TICK_DIV12: pick = st;
         TICK_EXT8:  pick = et;
         TICK_SYS:   pick = 1'b1;
      endcase
   endfunction

   assign tick_low  = pick(src_low, sys_tick, ext_tick_reg);
   assign tick_high = pick(src_high, sys_tick, ext_tick_reg);

   // Count enables for each byte
   always_comb begin
      if (split) begin
         en_low  = tick_low;
         en_high = tick_high && run;
      end else begin
         en_low  = tick_low && run;
         en_high = en_low && (count_low_reg == 8'hff);
      end
   end
   assign low_wrap  = en_low && (count_low_reg == 8'hff);
   assign high_wrap = en_high && (count_high_reg == 8'hff);

   // Low count byte
   always_ff @(posedge clk_sys_i) begin
      if (reset_i) begin
         count_low_reg <= `RESET_BYTE;
      end else if (wr_low) begin
         count_low_reg <= reg_wdata_i;
      end else if (split ? low_wrap : (low_wrap && high_wrap)) begin
         count_low_reg <= reload_low_reg;
      end else if (en_low) begin
         count_low_reg <= count_low_reg + 8'h01;
      end
   end

   // High count byte
   always_ff @(posedge clk_sys_i) begin
      if (reset_i) begin
         count_high_reg <= `RESET_BYTE;
      end else if (wr_high) begin
         count_high_reg <= reg_wdata_i;
      end else if (high_wrap) begin
         count_high_reg <= reload_high_reg;
      end else if (en_high) begin
         count_high_reg <= count_high_reg + 8'h01;
      end
   end

   // Reload bytes, written only by software
   always_ff @(posedge clk_sys_i) begin
      if (reset_i) begin
         reload_low_reg  <= `RESET_BYTE;
         reload_high_reg <= `RESET_BYTE;
      end else if (reg_write_i && reg_addr_i == `ADDR_RELOAD_LOW) begin
         reload_low_reg <= reg_wdata_i;
      end else if (reg_write_i && reg_addr_i == `ADDR_RELOAD_HIGH) begin
         reload_high_reg <= reg_wdata_i;
      end
   end

   // Control register; hardware set wins over a software clear
   always_ff @(posedge clk_sys_i) begin
      if (reset_i) begin
         control_reg <= `RESET_BYTE;
      end else begin
         if (wr_ctrl) begin
            control_reg <= reg_wdata_i & `CONTROL_WMASK;
         end
         if (high_wrap) begin
            control_reg[`BIT_HIGH_OVF] <= 1'b1;
         end
         if (low_wrap) begin
            control_reg[`BIT_LOW_OVF] <= 1'b1;
         end
      end
   end

   // Read data
   always_ff @(posedge clk_sys_i) begin
      if (reset_i) begin
         reg_rdata_o <= `RESET_BYTE;
      end else begin
         unique case (reg_addr_i)
            `ADDR_CONTROL:     reg_rdata_o <= control_reg;
            `ADDR_RELOAD_LOW:  reg_rdata_o <= reload_low_reg;
            `ADDR_RELOAD_HIGH: reg_rdata_o <= reload_high_reg;
            `ADDR_COUNT_LOW:   reg_rdata_o <= count_low_reg;
            `ADDR_COUNT_HIGH:  reg_rdata_o <= count_high_reg;
            default:           reg_rdata_o <= 8'h00;
         endcase
      end
   end

   // Interrupt level from the sticky flags
   always_ff @(posedge clk_sys_i) begin
      if (reset_i) begin
         irq_o <= 1'b0;
      end else begin
         irq_o <= timer_irq_enable_i && (control_reg[`BIT_HIGH_OVF] ||
                  (control_reg[`BIT_LOW_IRQ_EN] && control_reg[`BIT_LOW_OVF]));
      end
   end

   // Checks
   property p_high_flag;
      @(posedge clk_sys_i) disable iff (reset_i)
      high_wrap |=> control_reg[`BIT_HIGH_OVF];
   endproperty
   a_high_flag: assert property (p_high_flag) else $error("high flag not set");

   property p_low_flag;
      @(posedge clk_sys_i) disable iff (reset_i)
      low_wrap |=> control_reg[`BIT_LOW_OVF];
   endproperty
   a_low_flag: assert property (p_low_flag) else $error("low flag not set");

   property p_sticky;
      @(posedge clk_sys_i) disable iff (reset_i)
      control_reg[`BIT_HIGH_OVF] && !wr_ctrl |=> control_reg[`BIT_HIGH_OVF];
   endproperty
   a_sticky: assert property (p_sticky) else $error("flag cleared by hardware");

   property p_unused;
      @(posedge clk_sys_i) disable iff (reset_i)
      control_reg[4] == 1'b0 && control_reg[1] == 1'b0;
   endproperty
   a_unused: assert property (p_unused) else $error("unused bit set");

   property p_reload16;
      @(posedge clk_sys_i) disable iff (reset_i)
      !split && high_wrap && low_wrap && !wr_low && !wr_high |=>
         count_low_reg == $past(reload_low_reg) && count_high_reg == $past(reload_high_reg);
   endproperty
   a_reload16: assert property (p_reload16) else $error("16-bit reload wrong");

   property p_stop16;
      @(posedge clk_sys_i) disable iff (reset_i)
      !split && !run && !wr_low |=> $stable(count_low_reg);
   endproperty
   a_stop16: assert property (p_stop16) else $error("stopped timer counted");

   property p_split_high_gate;
      @(posedge clk_sys_i) disable iff (reset_i)
      split && !run && !wr_high |=> $stable(count_high_reg);
   endproperty
   a_split_high_gate: assert property (p_split_high_gate) else $error("high ran");

   property p_split_low_free;
      @(posedge clk_sys_i) disable iff (reset_i)
      split && low_clock_select_i && !wr_low && count_low_reg != 8'hff |=>
         count_low_reg == $past(count_low_reg) + 8'h01;
   endproperty
   a_split_low_free: assert property (p_split_low_free) else $error("low not free");

   property p_write_wins;
      @(posedge clk_sys_i) disable iff (reset_i)
      wr_low |=> count_low_reg == $past(reg_wdata_i);
   endproperty
   a_write_wins: assert property (p_write_wins) else $error("write lost");

   property p_irq;
      @(posedge clk_sys_i) disable iff (reset_i)
      timer_irq_enable_i && control_reg[`BIT_HIGH_OVF] |=> irq_o;
   endproperty
   a_irq: assert property (p_irq) else $error("irq missing");

   property p_low_irq;
      @(posedge clk_sys_i) disable iff (reset_i)
      timer_irq_enable_i && control_reg[`BIT_LOW_IRQ_EN] && control_reg[`BIT_LOW_OVF]
         |=> irq_o;
   endproperty
   a_low_irq: assert property (p_low_irq) else $error("low irq missing");

   property p_no_irq;
      @(posedge clk_sys_i) disable iff (reset_i)
      !timer_irq_enable_i |=> !irq_o;
   endproperty
   a_no_irq: assert property (p_no_irq) else $error("irq while disabled");

   property p_split_reload;
      @(posedge clk_sys_i) disable iff (reset_i)
      split && low_wrap && !wr_low |=> count_low_reg == $past(reload_low_reg);
   endproperty
   a_split_reload: assert property (p_split_reload) else $error("split low reload wrong");

   property p_reload_kept;
      @(posedge clk_sys_i) disable iff (reset_i)
      !(reg_write_i && reg_addr_i == `ADDR_RELOAD_HIGH) |=> $stable(reload_high_reg);
   endproperty
   a_reload_kept: assert property (p_reload_kept) else $error("reload changed");

   c_wrap16: cover property (@(posedge clk_sys_i) disable iff (reset_i) !split && high_wrap);
   c_split_low: cover property (@(posedge clk_sys_i) disable iff (reset_i) split && low_wrap);
   c_ext_tick: cover property (@(posedge clk_sys_i) disable iff (reset_i) ext_tick_reg);
   c_irq: cover property (@(posedge clk_sys_i) disable iff (reset_i) $rose(irq_o));
endmodule
`default_nettype wire

/* verif/tb_top.sv */
// Self-checking testbench for the split auto-reload timer
`default_nettype none
`include "split_timer_params.svh"
module tb_top;
   timeunit 1ns;
   timeprecision 1ns;
   import split_timer_pkg::*;

   // Design connections
   logic        clk_sys_i;
   logic        reset_i;
   logic [7:0]  reg_addr_i;
   byte_t       reg_wdata_i;
   logic        reg_write_i;
   byte_t       reg_rdata_o;
   logic        high_clock_select_i;
   logic        low_clock_select_i;
   logic        timer_irq_enable_i;
   logic        ext_osc_i;
   logic        irq_o;
   int          mismatches;
   int          check_count;
   byte_t       rd;

   split_auto_reload_timer dut (
      .clk_sys_i           (clk_sys_i),
      .reset_i             (reset_i),
      .reg_addr_i          (reg_addr_i),
      .reg_wdata_i         (reg_wdata_i),
      .reg_write_i         (reg_write_i),
      .reg_rdata_o         (reg_rdata_o),
      .high_clock_select_i (high_clock_select_i),
      .low_clock_select_i  (low_clock_select_i),
      .timer_irq_enable_i  (timer_irq_enable_i),
      .ext_osc_i           (ext_osc_i),
      .irq_o               (irq_o)
   );

   // System clock at 100 MHz
   initial begin
      clk_sys_i = 1'b0;
      forever #5 clk_sys_i = ~clk_sys_i;
   end

   // Counts and reports one comparison
   task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
      check_count++;
      if (seen !== exp) begin
         mismatches++;
         $display("ERROR %s expected %h seen %h", name, exp, seen);
      end
   endtask

   // Verdict and end of run
   task automatic results();
      if (mismatches == 0 && check_count > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask

   // One-cycle write strobe, taken at the second edge
   task automatic wr(input logic [7:0] a, input byte_t d);
      @(posedge clk_sys_i);
      reg_addr_i  <= a;
      reg_wdata_i <= d;
      reg_write_i <= 1'b1;
      @(posedge clk_sys_i);
      reg_write_i <= 1'b0;
   endtask

   // Registered read: data settles one edge after the address
   task automatic rdx(input logic [7:0] a);
      @(posedge clk_sys_i);
      reg_addr_i <= a;
      @(posedge clk_sys_i);
      #1 rd = reg_rdata_o;
   endtask

   task automatic cyc(input int n);
      repeat (n) @(posedge clk_sys_i);
      #1;
   endtask

   // Reset values, unused bits and an unmapped address
   task automatic t_reset();
      for (int a = 8'h90; a <= 8'h95; a++) begin
         rdx(8'(a));
         check("reset_value", rd, 8'h00);
      end
      wr(`ADDR_CONTROL, 8'h12);
      rdx(`ADDR_CONTROL);
      check("unused_bits", rd, 8'h00);
   endtask

   // 16-bit wrap reloads, sets flags, holds them, stops on run clear
   task automatic t_wide();
      @(posedge clk_sys_i);
      low_clock_select_i <= 1'b1;
      wr(`ADDR_RELOAD_LOW, 8'h34);
      wr(`ADDR_RELOAD_HIGH, 8'h12);
      wr(`ADDR_COUNT_LOW, 8'hfe);
      wr(`ADDR_COUNT_HIGH, 8'hff);
      wr(`ADDR_CONTROL, 8'h04);
      cyc(20);
      check("irq_wide", {7'h0, irq_o}, 8'h01);
      wr(`ADDR_CONTROL, 8'hc0);
      cyc(30);
      rdx(`ADDR_CONTROL);
      check("flags_wide", rd, 8'hc0);
      rdx(`ADDR_COUNT_HIGH);
      check("count_high_reload", rd, 8'h12);
      rdx(`ADDR_COUNT_LOW);
      cyc(5);
      check("stopped", reg_rdata_o, rd);
      check("count_low_stop", rd, 8'h48);
      rdx(`ADDR_RELOAD_LOW);
      check("reload_low_kept", rd, 8'h34);
      wr(`ADDR_CONTROL, 8'h00);
      cyc(3);
      check("irq_cleared", {7'h0, irq_o}, 8'h00);
   endtask

   // Split mode: low free-running, high gated, per-byte reload and flags
   task automatic t_split();
      wr(`ADDR_RELOAD_LOW, 8'h80);
      wr(`ADDR_RELOAD_HIGH, 8'hf0);
      wr(`ADDR_COUNT_LOW, 8'hf0);
      wr(`ADDR_COUNT_HIGH, 8'h55);
      wr(`ADDR_CONTROL, 8'h08);
      cyc(30);
      rdx(`ADDR_COUNT_HIGH);
      check("high_gated", rd, 8'h55);
      rdx(`ADDR_CONTROL);
      check("low_flag_split", rd, 8'h48);
      rdx(`ADDR_COUNT_LOW);
      check("low_reload", {7'h0, rd >= 8'h80}, 8'h01);
      check("irq_no_low_en", {7'h0, irq_o}, 8'h00);
      wr(`ADDR_CONTROL, 8'h68);
      cyc(3);
      check("irq_low_en", {7'h0, irq_o}, 8'h01);
      @(posedge clk_sys_i);
      high_clock_select_i <= 1'b1;
      wr(`ADDR_CONTROL, 8'h0c);
      cyc(200);
      rdx(`ADDR_CONTROL);
      check("high_flag_split", rd, 8'hcc);
      check("irq_high", {7'h0, irq_o}, 8'h01);
      @(posedge clk_sys_i);
      timer_irq_enable_i <= 1'b0;
      cyc(2);
      check("irq_disabled", {7'h0, irq_o}, 8'h00);
      @(posedge clk_sys_i);
      timer_irq_enable_i <= 1'b1;
      wr(`ADDR_CONTROL, 8'h08);
      rdx(`ADDR_COUNT_HIGH);
      check("high_reload", {7'h0, rd >= 8'hf0}, 8'h01);
      @(posedge clk_sys_i);
      high_clock_select_i <= 1'b0;
   endtask

   // Divided-by-12 tick on the low byte in split mode
   task automatic t_div12();
      @(posedge clk_sys_i);
      low_clock_select_i <= 1'b0;
      wr(`ADDR_COUNT_LOW, 8'h00);
      cyc(120);
      wr(`ADDR_CONTROL, 8'h00);
      rdx(`ADDR_COUNT_LOW);
      check("div12_count", {7'h0, rd >= 8'h09 && rd <= 8'h0b}, 8'h01);
   endtask

   // External oscillator divided by 8, synchronized, in 16-bit mode
   task automatic t_ext();
      wr(`ADDR_CONTROL, 8'h01);
      wr(`ADDR_COUNT_LOW, 8'h00);
      wr(`ADDR_COUNT_HIGH, 8'h00);
      wr(`ADDR_CONTROL, 8'h05);
      repeat (128) begin
         @(posedge clk_sys_i);
         ext_osc_i <= ~ext_osc_i;
         @(posedge clk_sys_i);
      end
      cyc(10);
      wr(`ADDR_CONTROL, 8'h01);
      rdx(`ADDR_COUNT_LOW);
      check("ext_count", rd, 8'h08);
      rdx(`ADDR_COUNT_HIGH);
      check("ext_high", rd, 8'h00);
   endtask

   // Watchdog
   initial begin
      #200000;
      mismatches++;
      results();
   end

   // Main sequence
   initial begin
      mismatches = 0;
      check_count = 0;
      reset_i = 1'b1;
      reg_addr_i = 8'h00;
      reg_wdata_i = 8'h00;
      reg_write_i = 1'b0;
      high_clock_select_i = 1'b0;
      low_clock_select_i = 1'b0;
      timer_irq_enable_i = 1'b1;
      ext_osc_i = 1'b0;
      repeat (16) @(posedge clk_sys_i);
      reset_i <= 1'b0;
      t_reset();
      t_wide();
      t_split();
      t_div12();
      t_ext();
      results();
   end
endmodule
`default_nettype wire
